// ==== design/clocked_serial_channel_master_tx.sv ====
// Notes on behaviour
// - stop trigger is a pulse, never stored
// - enable status readable, cleared by stop trigger
// - clock level writable while channel stopped
// - data level writable while output disabled
// - three lines, master or slave clocking
// - seven or eight bits, either bit order
// - fastest clock: first channel /2, else /4
// - prescaler and counter set master period
// - slave clock up to one sixth rate
// - interrupt at word end or buffer empty
// - data phase: first bit half clock early
// - clock phase bit inverts serial clock
// - write while full overwrites pending word silently
// - any channel in slave mode receives on clock without processor
// - slave select exists on first channel only
// - overrun flag on receive, none for transmit
// - slave select high blocks slave-mode transfers
// - gate off: writes ignored, defaults read
`timescale 1ns/1ps
module clocked_serial_channel_master_tx #(
    parameter bit first_channel = 1'b1
) (
    input  wire logic                                        clk,
    input  wire logic                                        reset,
    input  wire logic                                        unit_clock_gate_enable,
    input  wire logic                                        chan_start_trigger,
    input  wire logic                                        chan_stop_trigger,
    output logic                                             chan_enable_status,
    input  wire logic                                        slave_mode,
    input  wire logic                                        interrupt_source_select,
    input  wire logic                                        data_phase_sel,
    input  wire logic                                        clock_phase_sel,
    input  wire logic                                        word_len8,
    input  wire logic                                        lsb_first,
    input  wire logic [serial_channel_pkg::prescale_width-1:0] prescale_sel,
    input  wire logic [serial_channel_pkg::count_width-1:0]  divider_count,
    input  wire logic                                        serial_output_enable,
    input  wire logic                                        out_levels_write,
    input  wire logic                                        clock_level_wdata,
    input  wire logic                                        data_level_wdata,
    output logic                                             clock_out_level,
    output logic                                             data_out_level,
    input  wire logic                                        chan_data_write,
    input  wire logic [serial_channel_pkg::data_width-1:0]   chan_data_wdata,
    output logic                                             buffer_full_flag,
    output logic                                             transfer_busy,
    output logic                                             chan_transfer_interrupt,
    output logic                                             overrun_flag,
    input  wire logic                                        overrun_clear,
    output logic [serial_channel_pkg::data_width-1:0]        rx_data,
    output logic                                             rx_valid,
    input  wire logic                                        rx_ready,
    input  wire logic                                        slave_select_n,
    input  wire logic                                        sck_in,
    output logic                                             sck_out,
    output logic                                             sck_oe,
    input  wire logic                                        sdi,
    output logic                                             sdo
);
    typedef struct packed {
        serial_channel_pkg::chan_fsm_type st;
        logic                             enabled;
        logic                             phase;
        logic [3:0]                       bits;
        logic [7:0]                       tx;
        logic [7:0]                       rx;
        logic [7:0]                       data;
        logic                             bff;
        logic                             ckl;
        logic                             dol;
        logic                             ovf;
        logic                             irq;
        logic [2:0]                       sck_s;
        logic [2:0]                       sdi_s;
        logic [2:0]                       ss_s;
        logic                             sck_f;
        logic                             sdi_f;
        logic                             ss_f;
    } chan_state_type;

    localparam chan_state_type reset_value = '{
        st:      serial_channel_pkg::idle_state,
        enabled: 1'b0,
        phase:   1'b0,
        bits:    4'h0,
        tx:      8'h00,
        rx:      8'h00,
        data:    8'h00,
        bff:     1'b0,
        ckl:     serial_channel_pkg::clock_level_reset,
        dol:     serial_channel_pkg::data_level_reset,
        ovf:     1'b0,
        irq:     1'b0,
        sck_s:   serial_channel_pkg::sync_high,
        sdi_s:   serial_channel_pkg::sync_low,
        ss_s:    serial_channel_pkg::sync_high,
        sck_f:   1'b1,
        sdi_f:   1'b0,
        ss_f:    1'b1
    };

    chan_state_type s;
    chan_state_type next_s;
    logic           tick;
    logic           master;
    logic           ev;
    logic           pin_active;
    logic           word_done;
    logic [7:0]     word_data;
    logic           rx_in_ready;
    logic [3:0]     len;

    // ********************************************************
    // bit order and word length helpers
    // ********************************************************
    function automatic logic out_bit(input logic [7:0] sr, input logic lsb, input logic l8);
        out_bit = lsb ? sr[0] : (l8 ? sr[7] : sr[6]);
    endfunction

    function automatic logic [7:0] shift_word(input logic [7:0] sr, input logic lsb);
        shift_word = lsb ? {1'b1, sr[7:1]} : {sr[6:0], 1'b1};
    endfunction

    function automatic logic [7:0] take_bit(input logic [7:0] sr, input logic lsb, input logic b);
        take_bit = lsb ? {b, sr[7:1]} : {sr[6:0], b};
    endfunction

    // ********************************************************
    // master shift clock
    // ********************************************************
    clock_rate_divider #(
        .prescale_width (serial_channel_pkg::prescale_width),
        .count_width    (serial_channel_pkg::count_width),
        .min_half       (first_channel ? serial_channel_pkg::min_half_first : serial_channel_pkg::min_half_other)
    ) divider (
        .clk           (clk),
        .reset         (reset),
        .run           (s.enabled && master && s.st == serial_channel_pkg::shift_state),
        .prescale_sel  (prescale_sel),
        .divider_count (divider_count),
        .tick          (tick)
    );

    // ********************************************************
    // received words wait here, two deep, so a stalled reader loses none until both are full
    // ********************************************************
    rx_word_buffer #(
        .width (serial_channel_pkg::data_width),
        .depth (serial_channel_pkg::rx_depth)
    ) rx_buffer (
        .clk       (clk),
        .reset     (reset || !unit_clock_gate_enable),
        .in_valid  (word_done),
        .in_ready  (rx_in_ready),
        .in_data   (word_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ********************************************************
    // channel sequencing
    // ********************************************************
    always_comb begin
        next_s    = s;
        word_done = 1'b0;
        word_data = 8'h00;
        master    = !slave_mode;
        len       = word_len8 ? serial_channel_pkg::long_len : serial_channel_pkg::short_len;
        next_s.irq = 1'b0;

        // three-stage pin sync; a change counts when stages two and three agree
        next_s.sck_s = {s.sck_s[1:0], sck_in};
        next_s.sdi_s = {s.sdi_s[1:0], sdi};
        next_s.ss_s  = {s.ss_s[1:0], slave_select_n};
        if (s.sck_s[1] == s.sck_s[2]) begin
            next_s.sck_f = s.sck_s[2];
        end
        if (s.sdi_s[1] == s.sdi_s[2]) begin
            next_s.sdi_f = s.sdi_s[2];
        end
        if (s.ss_s[1] == s.ss_s[2]) begin
            next_s.ss_f = s.ss_s[2];
        end

        // pin edge in slave mode, tick in master mode
        pin_active = ((s.sck_f ^ clock_phase_sel) == 1'b0);
        if (master) begin
            ev = tick;
        end else begin
            ev = (next_s.sck_f != s.sck_f) && (!first_channel || !s.ss_f);
            pin_active = ((next_s.sck_f ^ clock_phase_sel) == 1'b0);
        end

        if (overrun_clear) begin
            next_s.ovf = 1'b0;
        end
        if (out_levels_write) begin
            if (!s.enabled) begin
                next_s.ckl = clock_level_wdata;
            end
            if (!serial_output_enable) begin
                next_s.dol = data_level_wdata;
            end
        end
        if (chan_start_trigger) begin
            next_s.enabled = 1'b1;
        end

        if (s.enabled) begin
            // a slave with nothing queued still clocks out idle ones and receives
            if (s.st == serial_channel_pkg::idle_state &&
                (s.bff || (!master && ev && pin_active))) begin
                next_s.st    = serial_channel_pkg::shift_state;
                next_s.phase = 1'b0;
                next_s.bits  = 4'h0;
                next_s.tx    = s.bff ? s.data : serial_channel_pkg::idle_fill;
                next_s.bff   = 1'b0;
                if (s.bff && interrupt_source_select) begin
                    next_s.irq = 1'b1;
                end
                if (data_phase_sel) begin
                    if (serial_output_enable) begin
                        next_s.dol = out_bit(next_s.tx, lsb_first, word_len8);
                    end
                    next_s.tx = shift_word(next_s.tx, lsb_first);
                end
            end

            if (next_s.st == serial_channel_pkg::shift_state && ev) begin
                if (!next_s.phase && (master || pin_active)) begin
                    if (master) begin
                        next_s.ckl = clock_phase_sel;
                    end
                    if (!data_phase_sel) begin
                        if (serial_output_enable) begin
                            next_s.dol = out_bit(next_s.tx, lsb_first, word_len8);
                        end
                        next_s.tx = shift_word(next_s.tx, lsb_first);
                    end else begin
                        next_s.rx = take_bit(next_s.rx, lsb_first, s.sdi_f);
                    end
                    next_s.phase = 1'b1;
                end else if (next_s.phase && (master || !pin_active)) begin
                    if (master) begin
                        next_s.ckl = !clock_phase_sel;
                    end
                    if (!data_phase_sel) begin
                        next_s.rx = take_bit(next_s.rx, lsb_first, s.sdi_f);
                    end
                    next_s.phase = 1'b0;
                    next_s.bits  = next_s.bits + 4'h1;
                    if (next_s.bits == len) begin
                        word_done = 1'b1;
                        if (word_len8) begin
                            word_data = next_s.rx;
                        end else if (lsb_first) begin
                            word_data = {1'b0, next_s.rx[7:1]};
                        end else begin
                            word_data = {1'b0, next_s.rx[6:0]};
                        end
                        next_s.st = serial_channel_pkg::idle_state;
                        if (!interrupt_source_select) begin
                            next_s.irq = 1'b1;
                        end
                        if (!rx_in_ready) begin
                            next_s.ovf = 1'b1;
                        end
                    end else if (data_phase_sel) begin
                        if (serial_output_enable) begin
                            next_s.dol = out_bit(next_s.tx, lsb_first, word_len8);
                        end
                        next_s.tx = shift_word(next_s.tx, lsb_first);
                    end
                end
            end
        end

        // a late write replaces the pending word and wins over the load
        if (chan_data_write) begin
            next_s.data = chan_data_wdata;
            next_s.bff  = 1'b1;
        end
        // levels stay where they were, so the pins hold still
        if (chan_stop_trigger) begin
            next_s.enabled = 1'b0;
            next_s.st      = serial_channel_pkg::idle_state;
            next_s.phase   = 1'b0;
        end
        if (!unit_clock_gate_enable) begin
            next_s = reset_value;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= reset_value;
        end else begin
            s <= next_s;
        end
    end

    assign chan_enable_status      = s.enabled;
    assign buffer_full_flag        = s.bff;
    assign transfer_busy           = (s.st == serial_channel_pkg::shift_state);
    assign chan_transfer_interrupt = s.irq;
    assign overrun_flag            = s.ovf;
    assign clock_out_level         = s.ckl;
    assign data_out_level          = s.dol;
    assign sck_out                 = s.ckl;
    assign sck_oe                  = master;
    assign sdo                     = s.dol;

    // ********************************************************
    // checks
    // ********************************************************
    chk_stop_clears_status: assert property (@(posedge clk) disable iff (reset)
        chan_stop_trigger |=> !chan_enable_status && !transfer_busy) else $error("stop left channel on");
    chk_gate_reads_default: assert property (@(posedge clk) disable iff (reset)
        !unit_clock_gate_enable |=> !chan_enable_status && !buffer_full_flag && !overrun_flag)
        else $error("gated unit not at defaults");
    chk_clock_level_write: assert property (@(posedge clk) disable iff (reset)
        (unit_clock_gate_enable && !chan_enable_status && out_levels_write)
        |=> clock_out_level == $past(clock_level_wdata)) else $error("clock level not written");
    chk_data_level_write: assert property (@(posedge clk) disable iff (reset)
        (unit_clock_gate_enable && !serial_output_enable && out_levels_write)
        |=> data_out_level == $past(data_level_wdata)) else $error("data level not written");
    chk_stopped_hold: assert property (@(posedge clk) disable iff (reset)
        (!chan_enable_status && !out_levels_write && unit_clock_gate_enable) ##1 unit_clock_gate_enable
        |-> $stable(clock_out_level) && $stable(data_out_level)) else $error("stopped pins moved");
    chk_overwrite_full: assert property (@(posedge clk) disable iff (reset)
        (chan_data_write && unit_clock_gate_enable) |=> buffer_full_flag && s.data == $past(chan_data_wdata))
        else $error("write did not refill buffer");
    chk_end_clock_idle: assert property (@(posedge clk) disable iff (reset)
        (chan_transfer_interrupt && !$past(interrupt_source_select) && !$past(slave_mode))
        |-> clock_out_level == !$past(clock_phase_sel)) else $error("clock not idle at word end");
    chk_irq_single_pulse: assert property (@(posedge clk) disable iff (reset)
        chan_transfer_interrupt |=> !chan_transfer_interrupt) else $error("interrupt longer than a pulse");
    chk_overrun_on_stall: assert property (@(posedge clk) disable iff (reset)
        (word_done && !rx_in_ready && unit_clock_gate_enable) |=> overrun_flag)
        else $error("lost word without overrun");
endmodule

// ==== design/serial_channel_pkg.sv ====
package serial_channel_pkg;

    // ********************************************************
    // word and clock geometry
    // ********************************************************
    localparam int            data_width     = 8;
    localparam logic [3:0]    short_len      = 4'h7;
    localparam logic [3:0]    long_len       = 4'h8;
    localparam int            prescale_width = 4;
    localparam int            count_width    = 7;
    localparam int            min_half_first = 1;
    localparam int            min_half_other = 2;
    localparam int            rx_depth       = 2;

    // ********************************************************
    // reset values and slave idle fill
    // ********************************************************
    localparam logic          clock_level_reset = 1'b1;
    localparam logic          data_level_reset  = 1'b1;
    localparam logic [7:0]    idle_fill         = 8'hff;
    localparam logic [2:0]    sync_high         = 3'h7;
    localparam logic [2:0]    sync_low          = 3'h0;

    // ********************************************************
    // channel states
    // ********************************************************
    typedef enum logic [0:0] {
        idle_state  = 1'b0,
        shift_state = 1'b1
    } chan_fsm_type;

endpackage

// ==== design/clock_rate_divider.sv ====
`timescale 1ns/1ps
module clock_rate_divider #(
    parameter int prescale_width = serial_channel_pkg::prescale_width,
    parameter int count_width    = serial_channel_pkg::count_width,
    parameter int min_half       = serial_channel_pkg::min_half_first
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      run,
    input  wire logic [prescale_width-1:0] prescale_sel,
    input  wire logic [count_width-1:0]    divider_count,
    output logic                           tick
);
    localparam int tw = 2 ** prescale_width + count_width;

    typedef struct packed {
        logic [tw-1:0] cnt;
    } div_state_type;

    div_state_type  s;
    div_state_type  next_s;
    logic [tw-1:0]  half_len;

    // ********************************************************
    // half period = 2^prescale * (count + 1) clocks, but never fewer than min_half
    // ********************************************************
    always_comb begin
        half_len = (tw'(divider_count) + tw'(1)) << prescale_sel;
        if (half_len < tw'(min_half)) begin
            half_len = tw'(min_half);
        end
        tick = run && (s.cnt == half_len - tw'(1));
        next_s = s;
        if (!run || tick) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + tw'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    chk_half_period_min: assert property (@(posedge clk) disable iff (reset)
        (tick && min_half > 1) |=> !tick) else $error("shift clock faster than allowed");
endmodule

// ==== design/rx_word_buffer.sv ====
`timescale 1ns/1ps
module rx_word_buffer #(
    parameter int width = serial_channel_pkg::data_width,
    parameter int depth = serial_channel_pkg::rx_depth
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [width-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [width-1:0]      out_data
);
    localparam int cw = $clog2(depth + 1);

    typedef struct packed {
        logic [depth-1:0][width-1:0] entry;
        logic [cw-1:0]               count;
    } buf_state_type;

    buf_state_type  s;
    buf_state_type  next_s;
    logic           push;
    logic           pop;
    logic [cw-1:0]  slot;

    // head entry is a flop, so read data leave from a register
    assign in_ready  = (s.count != cw'(depth));
    assign out_valid = (s.count != '0);
    assign out_data  = s.entry[0];

    always_comb begin
        next_s = s;
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        slot   = pop ? s.count - cw'(1) : s.count;
        if (pop) begin
            for (int i = 0; i < depth - 1; i++) begin
                next_s.entry[i] = s.entry[i + 1];
            end
        end
        if (push) begin
            next_s.entry[slot] = in_data;
        end
        next_s.count = s.count + cw'(push) - cw'(pop);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    chk_buffer_full_stall: assert property (@(posedge clk) disable iff (reset)
        (s.count == cw'(depth) && !out_ready) |=> !in_ready) else $error("full buffer accepted a word");
endmodule

// ==== testbench/serial_slave_model.sv ====
`timescale 1ns/1ps
module serial_slave_model (
    input  wire logic       sck,
    input  wire logic       sdo,
    input  wire logic       clock_phase_sel,
    input  wire logic       data_phase_sel,
    input  wire logic       clear,
    output logic            sdi,
    output logic [7:0]      captured,
    output logic [4:0]      bit_count
);
    // ********************************************************
    // slave shifter
    // ********************************************************
    initial sdi = 1'h0;
    // samples on the edge the phase bits name; reply toggles so a stuck line shows
    always @(sck or posedge clear) begin
        if (clear) begin
            captured  = 8'h00;
            bit_count = 5'h00;
        end else if (sck === (!clock_phase_sel ^ data_phase_sel)) begin
            captured  = {captured[6:0], sdo};
            bit_count = bit_count + 5'h01;
            sdi       = ~sdi;
        end
    end
endmodule

// ==== testbench/clocked_serial_channel_master_tx_tb.sv ====
`timescale 1ns/1ps
module clocked_serial_channel_master_tx_tb;
    // ********************************************************
    // stimulus and checks
    // ********************************************************
    logic clk = 1'h0, reset = 1'h1, unit_clock_gate_enable = 1'h1, chan_start_trigger = 1'h0, slave_mode = 1'h0;
    logic chan_stop_trigger = 1'h0, interrupt_source_select = 1'h0, data_phase_sel = 1'h0, clock_phase_sel = 1'h0;
    logic word_len8 = 1'h1, lsb_first = 1'h0, serial_output_enable = 1'h0, out_levels_write = 1'h0, clr = 1'h0;
    logic clock_level_wdata = 1'h1, data_level_wdata = 1'h1, chan_data_write = 1'h0, overrun_clear = 1'h0;
    logic rx_ready = 1'h0, slave_select_n = 1'h1, sck_in = 1'h1, sdi, ibusy, hold;
    logic [3:0] prescale_sel = 4'h0;
    logic [6:0] divider_count = 7'h00;
    logic [7:0] chan_data_wdata = 8'h00, rx_data, cap;
    logic [4:0] bits;
    logic chan_enable_status, clock_out_level, data_out_level, buffer_full_flag, transfer_busy, sck_out, sck_oe;
    logic chan_transfer_interrupt, overrun_flag, rx_valid, sdo;
    int miscompares = 0, check_count = 0, cyc = 0, bcnt = 0, icnt = 0;
    clocked_serial_channel_master_tx clocked_serial_channel_master_tx_inst (.*);
    serial_slave_model serial_slave_model_inst (.sck(sck_out), .sdo(sdo), .clock_phase_sel(clock_phase_sel),
        .data_phase_sel(data_phase_sel), .clear(clr), .sdi(sdi), .captured(cap), .bit_count(bits));
    always #2 clk = ~clk;
    // ceiling far above the few hundred cycles the sequence needs
    always @(negedge clk) begin
        cyc++;
        if (transfer_busy === 1'h1) bcnt++;
        if (chan_transfer_interrupt === 1'h1) begin
            icnt++;
            ibusy = transfer_busy;
        end
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lvl(input logic c, input logic d);
        clock_level_wdata = c;
        data_level_wdata = d;
        out_levels_write = 1'h1;
        tick(1);
        out_levels_write = 1'h0;
        tick(1);
    endtask
    task automatic pulse_start(input logic s);
        chan_start_trigger = s;
        chan_stop_trigger = !s;
        tick(1);
        chan_start_trigger = 1'h0;
        chan_stop_trigger = 1'h0;
    endtask
    // m = {len8, lsb, ckp, dap, continuous}; the first write is overwritten while still pending
    task automatic send(input logic [4:0] m, input logic [3:0] ps, input logic [6:0] dc, input logic [7:0] d);
        logic [7:0] e;
        int h, n;
        pulse_start(1'h0);
        {word_len8, lsb_first, clock_phase_sel, data_phase_sel, interrupt_source_select} = m;
        lvl(!m[2], 1'h1);
        prescale_sel = ps;
        divider_count = dc;
        chan_data_wdata = ~d;
        chan_data_write = 1'h1;
        tick(1);
        chan_data_wdata = d;
        tick(1);
        chan_data_write = 1'h0;
        clr = 1'h1;
        tick(1);
        clr = 1'h0;
        bcnt = 0;
        icnt = 0;
        cmp(16'(buffer_full_flag), 16'h0001);
        pulse_start(1'h1);
        for (int i = 0; i < 3000 && !(bcnt > 0 && transfer_busy === 1'h0); i++) tick(1);
        tick(2);
        h = (dc + 1) << ps;
        n = m[4] ? 8 : 7;
        e = 8'h00;
        for (int i = 0; i < n; i++) e = {e[6:0], m[3] ? d[i] : d[n - 1 - i]};
        cmp(16'(cap), 16'(e));
        cmp(16'(bits), 16'(n));
        cmp(16'(bcnt), 16'(2 * h * n));
        cmp(16'(icnt), 16'h0001);
        cmp(16'(ibusy), 16'(m[0]));
        cmp(16'(clock_out_level), 16'(!m[2]));
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        tick(20);
        reset = 1'h0;
        tick(1);
        cmp(16'(chan_enable_status), 16'h0000);
        cmp(16'(sck_oe), 16'h0001);
        lvl(1'h0, 1'h0);
        cmp(16'(clock_out_level), 16'h0000);
        cmp(16'(data_out_level), 16'h0000);
        serial_output_enable = 1'h1;
        lvl(1'h1, 1'h1);
        cmp(16'(clock_out_level), 16'h0001);
        cmp(16'(data_out_level), 16'h0000);
        serial_output_enable = 1'h0;
        lvl(1'h1, 1'h1);
        serial_output_enable = 1'h1;
        pulse_start(1'h1);
        cmp(16'(chan_enable_status), 16'h0001);
        lvl(1'h0, 1'h1);
        cmp(16'(clock_out_level), 16'h0001);
        send(5'h10, 4'h0, 7'h00, 8'ha5);
        send(5'h09, 4'h1, 7'h01, 8'h3c);
        send(5'h1a, 4'h0, 7'h02, 8'h96);
        cmp(16'(overrun_flag), 16'h0001);
        cmp(16'(rx_valid), 16'h0001);
        overrun_clear = 1'h1;
        tick(1);
        overrun_clear = 1'h0;
        rx_ready = 1'h1;
        cmp(16'(overrun_flag), 16'h0000);
        send(5'h07, 4'h2, 7'h00, 8'h5a);
        chan_data_write = 1'h1;
        tick(1);
        chan_data_write = 1'h0;
        pulse_start(1'h1);
        tick(9);
        pulse_start(1'h0);
        hold = clock_out_level;
        cmp(16'(chan_enable_status), 16'h0000);
        cmp(16'(transfer_busy), 16'h0000);
        tick(8);
        cmp(16'(clock_out_level), 16'(hold));
        unit_clock_gate_enable = 1'h0;
        pulse_start(1'h1);
        cmp(16'(chan_enable_status), 16'h0000);
        unit_clock_gate_enable = 1'h1;
        slave_mode = 1'h1;
        clock_phase_sel = 1'h0;
        interrupt_source_select = 1'h0;
        pulse_start(1'h1);
        icnt = 0;
        for (int i = 0; i < 16; i++) begin
            sck_in = ~sck_in;
            tick(2);
            slave_select_n = (i < 1);
            tick(2);
        end
        tick(4);
        cmp(16'(sck_oe), 16'h0000);
        cmp(16'(icnt), 16'h0001);
        cmp(16'(transfer_busy), 16'h0000);
        tally_and_finish();
    end
endmodule
